// *** hw/agu_defines.svh ***
`ifndef AGU_DEFINES_SVH
`define AGU_DEFINES_SVH
`define AGU_STACK_SEL 4'hf
`define AGU_LSB_CLEAR 16'hfffe
`define AGU_OUT_RESET 16'h0000
`endif

// *** hw/agu_pkg.sv ***
package agu_pkg;
    typedef enum logic [3:0] {
        MODE_PLAIN = 4'b0001,
        MODE_PRE_INC = 4'b0010,
        MODE_POST_INC = 4'b0100,
        MODE_OFFSET = 4'b1000
    } addr_mode_t;
endpackage

// *** hw/bit_reversed_modulo_agu.sv ***
`timescale 1ns/1ps
`include "agu_defines.svh"
module bit_reversed_modulo_agu
    import agu_pkg::*;
#(
    parameter int AW = 16
)
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic req_valid_in,
    input wire logic x_agu_in,
    input wire logic write_in,
    input wire logic byte_in,
    input wire addr_mode_t mode_in,
    input wire logic [3:0] ptr_index_in,
    input wire logic [AW-1:0] ptr_value_in,
    input wire logic [AW-1:0] offset_in,
    input wire logic decrement_in,
    input wire logic mod_enable_in,
    input wire logic [3:0] mod_pointer_select_in,
    input wire logic [AW-1:0] mod_start_in,
    input wire logic [AW-1:0] mod_end_in,
    input wire logic bitrev_enable_in,
    input wire logic [3:0] bitrev_pointer_select_in,
    input wire logic [14:0] bitrev_pivot_in,
    output logic [AW-1:0] ea_out,
    output logic [AW-1:0] ptr_next_out,
    output logic ptr_we_out,
    output logic bitrev_used_out,
    output logic valid_out
);
    wire logic is_inc;
    wire logic bitrev_act;
    wire logic mod_act;
    wire logic [AW-1:0] pivot;
    wire logic [AW-1:0] rev_sum;
    wire logic [AW-1:0] lin_sum;
    wire logic [AW-1:0] mod_sum;
    wire logic [AW-1:0] pre_ea;
    wire logic [AW-1:0] upd;
    wire logic [AW-1:0] ea_c;
    wire logic we_c;

    function automatic logic [AW-1:0] rev(input logic [AW-1:0] v);
        logic [AW-1:0] r;
        r = '0;
        for (int i = 0; i < AW; i++)
        begin
            r[i] = v[AW-1-i];
        end
        return r;
    endfunction

    assign is_inc = (mode_in == MODE_PRE_INC) || (mode_in == MODE_POST_INC);
    // Stack pointer excluded from reversal
    assign bitrev_act = bitrev_enable_in && x_agu_in && write_in && !byte_in
        && is_inc && (bitrev_pointer_select_in != `AGU_STACK_SEL)
        && (ptr_index_in == bitrev_pointer_select_in);
    assign mod_act = mod_enable_in && (ptr_index_in == mod_pointer_select_in)
        && (mode_in != MODE_PLAIN);
    // Pivot is a word count, shift to bytes
    // Sized cast instead of a zero-width replication when AW is 16
    assign pivot = AW'({bitrev_pivot_in, 1'b0});
    // Reversed-carry add: reverse, add, reverse back
    assign rev_sum = rev(rev(ptr_value_in) + rev(pivot)) & `AGU_LSB_CLEAR;
    assign lin_sum = decrement_in ? ptr_value_in - offset_in
                                  : ptr_value_in + offset_in;
    // Past-boundary detection, not just equality
    assign mod_sum = (!decrement_in && lin_sum > mod_end_in) ?
            lin_sum - mod_end_in - 16'h0001 + mod_start_in :
        (decrement_in && lin_sum < mod_start_in) ?
            mod_end_in + 16'h0001 - (mod_start_in - lin_sum) :
        lin_sum;
    assign upd = bitrev_act ? rev_sum : (mod_act ? mod_sum : lin_sum);
    assign pre_ea = (mode_in == MODE_POST_INC || mode_in == MODE_PLAIN) ?
        ptr_value_in : upd;
    assign ea_c = (mode_in == MODE_OFFSET) ? upd : pre_ea;
    assign we_c = (mode_in == MODE_PRE_INC) || (mode_in == MODE_POST_INC);

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ea_out <= `AGU_OUT_RESET;
            ptr_next_out <= `AGU_OUT_RESET;
            ptr_we_out <= 1'b0;
            bitrev_used_out <= 1'b0;
            valid_out <= 1'b0;
        end
        else
        begin
            ea_out <= ea_c;
            ptr_next_out <= upd;
            ptr_we_out <= req_valid_in && we_c;
            bitrev_used_out <= req_valid_in && bitrev_act;
            valid_out <= req_valid_in;
        end
    end

    a_offset_no_wb: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        req_valid_in && mode_in == MODE_OFFSET |=> !ptr_we_out)
        else $error("offset mode wrote pointer");
    a_stack_no_rev: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        bitrev_pointer_select_in == `AGU_STACK_SEL |=> !bitrev_used_out)
        else $error("stack select reversed");
    a_byte_no_rev: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        byte_in || !write_in || !x_agu_in |=> !bitrev_used_out)
        else $error("reversal outside x word write");
    a_rev_lsb: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        bitrev_used_out |-> ptr_next_out[0] == 1'b0)
        else $error("reversed address odd");
    a_inc_wrap: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        req_valid_in && mod_act && !bitrev_act && !decrement_in
        && mod_start_in <= mod_end_in |=> ptr_next_out <= $past(mod_end_in))
        else $error("increment beyond end");
    a_rev_prec: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        req_valid_in && bitrev_act |=> ptr_next_out == $past(rev_sum))
        else $error("modulo overrode reversal");
    a_enable_cond: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !bitrev_enable_in || !is_inc |=> !bitrev_used_out)
        else $error("reversal without enable");
    a_inc_wb: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        req_valid_in && is_inc |=> ptr_we_out && valid_out)
        else $error("missing write-back");

    // Several-step behaviour is spelled out as request and answer sequences
    sequence s_rev_req;
        req_valid_in && bitrev_act;
    endsequence

    sequence s_rev_done;
        bitrev_used_out && ptr_we_out && valid_out;
    endsequence

    sequence s_idle_req;
        !req_valid_in;
    endsequence

    sequence s_quiet_out;
        !valid_out && !ptr_we_out && !bitrev_used_out;
    endsequence

    a_rev_flags: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        s_rev_req |=> s_rev_done)
        else $error("reversed access not flagged");

    // Pulses must not leak into cycles without a request
    a_idle_quiet: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        s_idle_req |=> s_quiet_out)
        else $error("pulse without request");

    a_valid_pulse: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        req_valid_in |=> valid_out)
        else $error("missing valid pulse");

    a_plain_no_wb: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        req_valid_in && mode_in == MODE_PLAIN |=> !ptr_we_out)
        else $error("plain mode wrote pointer");

    a_post_ea: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        req_valid_in && mode_in == MODE_POST_INC
        |=> ea_out == $past(ptr_value_in))
        else $error("post-modify address not pointer");

    a_plain_ea: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        req_valid_in && mode_in == MODE_PLAIN
        |=> ea_out == $past(ptr_value_in))
        else $error("plain address not pointer");

    // Pre-modify hands out the updated address, so word alignment shows
    a_rev_even_ea: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        req_valid_in && bitrev_act && mode_in == MODE_PRE_INC
        |=> ea_out[0] == 1'b0)
        else $error("reversed address odd");

    // Bound only holds for jumps shorter than the buffer
    a_dec_wrap: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        req_valid_in && mod_act && !bitrev_act && decrement_in
        && mod_start_in <= mod_end_in
        |=> ptr_next_out >= $past(mod_start_in))
        else $error("decrement below start");

    a_lin_next: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        req_valid_in && !mod_act && !bitrev_act && !decrement_in
        && mode_in == MODE_PRE_INC
        |=> ptr_next_out == $past(ptr_value_in) + $past(offset_in))
        else $error("ordinary address wrong");
endmodule

// *** verification/bit_reversed_modulo_agu_test.sv ***
`timescale 1ns/1ps
module bit_reversed_modulo_agu_test;
    import agu_pkg::*;
    typedef struct packed {logic [3:0] m; logic [6:0] f; logic [3:0] s;
        logic [15:0] p, o, e, n; logic [2:0] r;} row_t;
    logic clk_in = 1'h0, reset_n_in = 1'h0, load = 1'h1, we, used, vld;
    logic [6:0] f = 7'h0;
    logic [3:0] m = 4'h1, s = 4'h2;
    logic [15:0] p = 16'h1000, o = 16'h2, ptr, ea, nx;
    logic [15:0] chain [4] = '{16'h1000, 16'h1010, 16'h1008, 16'h1018};
    int fails = 0, cmp_count = 0;
    // Enable toggles right before the reads through the pointer in rows[3] and rows[6]
    row_t rows [11] = '{
    '{4'h2,7'h69,4'h2,16'h1018,16'h2,16'h1004,16'h1004,3'h7},
    '{4'h4,7'h79,4'h2,16'h1000,16'h1,16'h1000,16'h1001,3'h6},
    '{4'h4,7'h49,4'h2,16'h1000,16'h2,16'h1000,16'h1002,3'h6},
    '{4'h4,7'h6a,4'h5,16'h101e,16'h4,16'h101e,16'h1002,3'h6},
    '{4'h2,7'h6e,4'h2,16'h1002,16'h4,16'h101e,16'h101e,3'h6},
    '{4'h8,7'h6a,4'h2,16'h101e,16'h4,16'h1002,16'h0,3'h4},
    '{4'h4,7'h6b,4'h2,16'h1010,16'h2,16'h1010,16'h1008,3'h7},
    '{4'h2,7'h69,4'h2,16'h1001,16'h2,16'h1010,16'h1010,3'h7},
    '{4'h4,7'h69,4'hf,16'h1000,16'h2,16'h1000,16'h1002,3'h6},
    '{4'h4,7'h61,4'h2,16'h1000,16'h2,16'h1000,16'h1002,3'h6},
    '{4'h1,7'h69,4'h2,16'h1234,16'h2,16'h1234,16'h0,3'h4}};
    bit_reversed_modulo_agu dut_u (.clk_in, .reset_n_in, .req_valid_in(f[6]),
        .write_in(f[5]), .byte_in(f[4]), .x_agu_in(f[3]), .decrement_in(f[2]),
        .mod_enable_in(f[1]), .bitrev_enable_in(f[0]), .mode_in(addr_mode_t'(m)),
        .ptr_index_in(s), .mod_pointer_select_in(s), .ptr_value_in(ptr),
        .bitrev_pointer_select_in(s), .offset_in(o), .mod_start_in(16'h1000),
        .mod_end_in(16'h101f), .bitrev_pivot_in(15'h8), .ea_out(ea),
        .ptr_next_out(nx), .ptr_we_out(we), .bitrev_used_out(used),
        .valid_out(vld));
    ptr_file pf_u (.clk_in, .reset_n_in, .load_in(load), .load_value_in(p),
        .we_in(we), .next_in(nx), .ptr_out(ptr));
    task chk(input logic [15:0] seen, exp, input string what);
        cmp_count++;
        if (seen !== exp) $display("[FAIL] %s exp %h seen %h", what, exp, seen);
        fails += int'(seen !== exp);
    endtask
    task final_report;
        if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial forever #2 clk_in = ~clk_in;
    initial
    begin
        repeat (5) @(posedge clk_in);
        chk({13'h0, vld, we, used}, 16'h0, "reset");
        reset_n_in <= 1'h1;
        foreach (rows[i])
        begin
            {m, f, s, p, o} <= rows[i][81:35];
            @(posedge clk_in);
            #1 chk(ea, rows[i].e, "ea");
            if (rows[i].r[1]) chk(nx, rows[i].n, "next");
            chk({13'h0, vld, we, used}, {13'h0, rows[i].r}, "flags");
            @(posedge clk_in);
        end
        // Pointer now comes back from the core each cycle, offset ignored
        {m, f, p} <= {4'h4, 7'h69, 16'h1000};
        @(posedge clk_in);
        load <= 1'h0;
        foreach (chain[i])
        begin
            #1 chk(ea, chain[i], "chain");
            @(posedge clk_in);
        end
        final_report;
    end
endmodule

// *** verification/ptr_file.sv ***
`timescale 1ns/1ps
module ptr_file (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic load_in,
    input wire logic [15:0] load_value_in,
    input wire logic we_in,
    input wire logic [15:0] next_in,
    output logic [15:0] ptr_out
);
    logic [15:0] ptr;
    // Forwarding lets the core issue back to back through one pointer
    assign ptr_out = load_in ? load_value_in : (we_in ? next_in : ptr);
    always_ff @(posedge clk_in or negedge reset_n_in)
        if (!reset_n_in) ptr <= 16'h1000; // Base has zero low bits
        else if (load_in) ptr <= load_value_in;
        else if (we_in) ptr <= next_in;
endmodule
